// *** src/dgf_pkg.sv ***
// package: register map, layout and mode constants for the distributor control block
package dgf_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] DGF_CTRL_OFS   = 12'h000;
  localparam logic [11:0] DGF_STATUS_OFS = 12'h004;

  // field positions in the control word
  localparam int DGF_GRP0_BIT = 0;
  localparam int DGF_GRP1_BIT = 1;

  // reset values
  localparam logic [31:0] DGF_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DGF_ZERO     = 32'h0000_0000;

  // layout selection: single enable bit or two group enables, each with or without security
  typedef enum logic [1:0] {
    DGF_V1_NOSEC,
    DGF_V1_SEC,
    DGF_V2_NOSEC,
    DGF_V2_SEC
  } dgf_layout_e;

  // apb request carried as one struct
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
  } dgf_apb_req_s;

  // apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dgf_apb_rsp_s;

  // forward enables to the cpu interface logic
  typedef struct packed {
    logic grp1;
    logic grp0;
  } dgf_fwd_s;

endpackage

// *** src/dgf_bank.sv ***
// one banked copy of the control word: two enable bits with write masks
`timescale 1ns/1ps
module dgf_bank
  import dgf_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // write port
  input  wire logic wr,
  input  wire logic wr_grp0_ok,
  input  wire logic wr_grp1_ok,
  input  wire logic wdata_grp0,
  input  wire logic wdata_grp1,
  // stored value
  output dgf_fwd_s  value
);

  typedef struct packed {
    dgf_fwd_s bits;
  } dgf_bank_s;

  dgf_bank_s state;
  dgf_bank_s next_state;

  always_comb begin
    next_state = state;
    if (wr && wr_grp0_ok) begin
      next_state.bits.grp0 = wdata_grp0;
    end
    if (wr && wr_grp1_ok) begin
      next_state.bits.grp1 = wdata_grp1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{bits: '{grp1: DGF_CTRL_RST[DGF_GRP1_BIT], grp0: DGF_CTRL_RST[DGF_GRP0_BIT]}};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.bits;

endmodule

// *** src/dgf_ctrl.sv ***
// distributor control register with global forward enables, apb slave
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module dgf_ctrl
  import dgf_pkg::*;
#(
  parameter dgf_layout_e LAYOUT        = DGF_V2_SEC,
  parameter bit          HAS_LOCKDOWN  = 1'b1,
  parameter bit          V1_SEC_GRP1   = 1'b1
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  dgf_apb_req_s      apb_req,
  output dgf_apb_rsp_s      apb_rsp,
  // lockdown strap from the system, asynchronous
  input  wire logic         secure_config_lock,
  // pending interrupts offered by the distributor core
  input  wire logic         pend_grp0,
  input  wire logic         pend_grp1,
  // forwarding toward the cpu interfaces
  output dgf_fwd_s          fwd_enable,
  output dgf_fwd_s          fwd_valid
);

  initial begin
    if (!(LAYOUT inside {DGF_V1_NOSEC, DGF_V1_SEC, DGF_V2_NOSEC, DGF_V2_SEC})) begin
      $error("dgf_ctrl: unsupported layout");
    end
  end

  localparam bit SECURE = (LAYOUT == DGF_V1_SEC) || (LAYOUT == DGF_V2_SEC);
  localparam bit TWO_GROUP_SEC = (LAYOUT == DGF_V2_NOSEC) || (LAYOUT == DGF_V2_SEC)
                                 || (LAYOUT == DGF_V1_SEC && V1_SEC_GRP1);

  typedef struct packed {
    logic        lock_meta;
    logic        lock_sync;
    logic        rsp_ready;
    logic        rsp_err;
    logic [31:0] rdata;
    dgf_fwd_s    fwd;
  } dgf_ctrl_s;

  dgf_ctrl_s state;
  dgf_ctrl_s next_state;

  // banked copies
  dgf_fwd_s sec_copy;
  dgf_fwd_s ns_copy;

  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic nonsecure;
  logic wr_ctrl;
  logic wr_sec;
  logic wr_ns;
  logic sec_grp0_ok;
  logic lane0;

  // access phase completes in one cycle: pready is asserted combinationally
  assign access     = apb_req.psel && apb_req.penable;
  assign hit_ctrl   = apb_req.paddr[11:2] == DGF_CTRL_OFS[11:2];
  assign hit_status = apb_req.paddr[11:2] == DGF_STATUS_OFS[11:2];
  // pprot[1] high marks a non-secure access; without security all is one copy
  assign nonsecure  = SECURE && apb_req.pprot[1];
  assign lane0      = apb_req.pstrb[0];
  assign wr_ctrl    = access && apb_req.pwrite && hit_ctrl && lane0;
  assign wr_sec     = wr_ctrl && !nonsecure;
  assign wr_ns      = wr_ctrl && nonsecure;

  // lock uses the synchronised level only
  assign sec_grp0_ok = !(HAS_LOCKDOWN && SECURE && state.lock_sync);

  dgf_bank u_sec (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr         (wr_sec),
    .wr_grp0_ok (sec_grp0_ok),
    .wr_grp1_ok (TWO_GROUP_SEC),
    .wdata_grp0 (apb_req.pwdata[DGF_GRP0_BIT]),
    .wdata_grp1 (apb_req.pwdata[DGF_GRP1_BIT]),
    .value      (sec_copy)
  );

  // the non-secure copy holds one bit only, kept in the grp0 slot
  dgf_bank u_ns (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr         (wr_ns),
    .wr_grp0_ok (1'b1),
    .wr_grp1_ok (1'b0),
    .wdata_grp0 (apb_req.pwdata[DGF_GRP0_BIT]),
    .wdata_grp1 (1'b0),
    .value      (ns_copy)
  );

  // effective forward enables per layout
  function automatic dgf_fwd_s eff_enables(dgf_fwd_s s, dgf_fwd_s n);
    dgf_fwd_s e;
    e = '0;
    unique case (LAYOUT)
      DGF_V1_NOSEC: begin
        e.grp0 = s.grp0;
        e.grp1 = s.grp0;
      end
      DGF_V1_SEC: begin
        e.grp0 = s.grp0;
        // group 1 follows the non-secure enable only; the optional secure bit 1 is stored but not used here
        e.grp1 = n.grp0;
      end
      DGF_V2_NOSEC: begin
        e.grp0 = s.grp0;
        e.grp1 = s.grp1;
      end
      DGF_V2_SEC: begin
        e.grp0 = s.grp0;
        // group 1 is on while either the non-secure bit or the secure bit 1 is set
        e.grp1 = n.grp0 | s.grp1;
      end
    endcase
    return e;
  endfunction

  // read view of the control word
  function automatic logic [31:0] ctrl_view(dgf_fwd_s s, dgf_fwd_s n, logic ns);
    logic [31:0] v;
    v = DGF_ZERO;
    if (ns) begin
      v[DGF_GRP0_BIT] = (LAYOUT == DGF_V2_SEC) ? (n.grp0 | s.grp1) : n.grp0;
    end else if (LAYOUT == DGF_V1_NOSEC) begin
      v[DGF_GRP0_BIT] = s.grp0;
    end else begin
      v[DGF_GRP0_BIT] = s.grp0;
      if (TWO_GROUP_SEC) begin
        v[DGF_GRP1_BIT] = (LAYOUT == DGF_V2_NOSEC) ? s.grp1 : (s.grp1 | n.grp0);
      end
    end
    return v;
  endfunction

  dgf_fwd_s eff;
  assign eff = eff_enables(sec_copy, ns_copy);

  always_comb begin
    next_state           = state;
    next_state.lock_meta = secure_config_lock;
    next_state.lock_sync = state.lock_meta;
    next_state.fwd       = eff;
    next_state.rsp_err   = 1'b0;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      if (hit_ctrl) begin
        next_state.rdata = ctrl_view(sec_copy, ns_copy, nonsecure);
      end else if (hit_status) begin
        next_state.rdata = {DGF_ZERO[31:3], state.lock_sync, eff.grp1, eff.grp0};
      end else begin
        next_state.rdata = DGF_ZERO;
      end
    end
    // unmapped addresses answer with an error
    if (apb_req.psel && !apb_req.penable) begin
      next_state.rsp_err = !(hit_ctrl || hit_status);
    end
    next_state.rsp_ready = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{lock_meta: 1'b0, lock_sync: 1'b0, rsp_ready: 1'b0, rsp_err: 1'b0,
                 rdata: DGF_ZERO, fwd: '0};
    end else begin
      state <= next_state;
    end
  end

  // zero wait states; the enable gates only forwarding, never the bus
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access && state.rsp_err;
  assign apb_rsp.prdata  = state.rdata;

  assign fwd_enable = state.fwd;
  assign fwd_valid.grp0 = state.fwd.grp0 && pend_grp0;
  assign fwd_valid.grp1 = state.fwd.grp1 && pend_grp1;

endmodule

// *** test/dgf_ctrl_properties.sv ***
// checker: forward enable and register access properties
`timescale 1ns/1ps
module dgf_ctrl_chk
  import dgf_pkg::*;
(
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // apb and system side
  input dgf_apb_req_s apb_req,
  input dgf_apb_rsp_s apb_rsp,
  input wire logic    secure_config_lock,
  input wire logic    pend_grp0,
  input wire logic    pend_grp1,
  // forwarding side
  input dgf_fwd_s     fwd_enable,
  input dgf_fwd_s     fwd_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctl;
  assign ctl = apb_req.psel && apb_req.penable && apb_req.paddr[11:2] == 10'h000;
  sequence s_wr(ns);
    ctl && apb_req.pwrite && apb_req.pstrb[0] && apb_req.pprot[1] == ns;
  endsequence
  // lock needs four samples: two sync flops plus margin
  sequence s_open;
    !secure_config_lock [*4];
  endsequence
  sequence s_held;
    secure_config_lock [*4];
  endsequence
  chk_valid_grp0: assert property (fwd_valid.grp0 == (fwd_enable.grp0 && pend_grp0))
    else $error("group 0 valid differs from enable and pending");
  chk_valid_grp1: assert property (fwd_valid.grp1 == (fwd_enable.grp1 && pend_grp1))
    else $error("group 1 valid differs from enable and pending");
  chk_ready_idle: assert property (ctl && !fwd_enable.grp0 |-> apb_rsp.pready)
    else $error("access stalled while forwarding off");
  chk_sec_grp0: assert property (s_open ##0 s_wr(1'b0) |-> ##2
    fwd_enable.grp0 == $past(apb_req.pwdata[0], 2)) else $error("secure group 0 write lost");
  chk_lock_grp0: assert property (s_held |-> ##2 $stable(fwd_enable.grp0))
    else $error("group 0 enable changed while locked");
  chk_ns_grp0: assert property (s_wr(1'b1) |-> ##2 $stable(fwd_enable.grp0))
    else $error("non-secure write moved group 0");
  chk_ns_grp1: assert property (s_wr(1'b1) ##0 apb_req.pwdata[0] |-> ##2 fwd_enable.grp1)
    else $error("non-secure write did not enable group 1");
  chk_sec_grp1: assert property (s_wr(1'b0) ##0 apb_req.pwdata[1] |-> ##2 fwd_enable.grp1)
    else $error("secure bit 1 did not enable group 1");
  chk_rsvd_zero: assert property (ctl && !apb_req.pwrite |-> apb_rsp.prdata[31:2] == 30'h0)
    else $error("reserved control bits read nonzero");
endmodule

bind dgf_ctrl dgf_ctrl_chk u_dgf_ctrl_chk (.pclk, .presetn, .apb_req, .apb_rsp,
  .secure_config_lock, .pend_grp0, .pend_grp1, .fwd_enable, .fwd_valid);

// *** test/dgf_cpu_model.sv ***
// model: cpu interface side, counts forwarded interrupt cycles
`timescale 1ns/1ps
module dgf_cpu_model
  import dgf_pkg::*;
(
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // forwarded interrupts, level with no handshake back
  input dgf_fwd_s     fwd_valid,
  output logic [15:0] taken_grp0,
  output logic [15:0] taken_grp1
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_grp0 <= 16'h0000;
      taken_grp1 <= 16'h0000;
    end else begin
      taken_grp0 <= taken_grp0 + 16'(fwd_valid.grp0);
      taken_grp1 <= taken_grp1 + 16'(fwd_valid.grp1);
    end
  end
endmodule

// *** test/distributor_global_forward_enable_tb.sv ***
// testbench: apb access to the forward enables, lock and status
`timescale 1ns/1ps
module distributor_global_forward_enable_tb;
  import dgf_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         lock;
  logic [1:0]   pend;
  logic [31:0]  r;
  int           mismatches;
  int           n_compared;
  int           cyc;
  logic [31:0]  q[$];
  dgf_apb_req_s req;
  dgf_apb_rsp_s rsp;
  dgf_fwd_s     fen;
  dgf_fwd_s     fval;
  dgf_ctrl u_dgf_ctrl (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .secure_config_lock(lock), .pend_grp0(pend[0]), .pend_grp1(pend[1]),
    .fwd_enable(fen), .fwd_valid(fval));
  dgf_cpu_model u_dgf_cpu_model (.pclk(pclk), .presetn(presetn), .fwd_valid(fval),
    .taken_grp0(), .taken_grp1());
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic ns, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d, 4'hf, {1'b0, ns, 1'b0}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task rd(input logic ns, input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, ns, a, 32'h0000_0000);
  endtask
  // read results are scored where they appear, against the oldest note
  always @(posedge pclk)
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      if (!req.pwrite)
        chk(rsp.prdata, q.pop_front());
      chk({31'h0000_0000, rsp.pslverr}, {31'h0000_0000, !(req.paddr[11:2] inside
        {DGF_CTRL_OFS[11:2], DGF_STATUS_OFS[11:2]})});
    end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    presetn = 1'b0;
    lock = 1'b0;
    pend = 2'b00;
    req = '0;
    void'($urandom(12197));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(1'b0, DGF_CTRL_OFS, DGF_CTRL_RST);
    rd(1'b0, DGF_STATUS_OFS, DGF_ZERO);
    $display("reset test done");
    repeat (6) begin
      r = $urandom;
      apb(1'b1, 1'b0, DGF_CTRL_OFS, r);
      rd(1'b0, DGF_CTRL_OFS, {30'h0000_0000, r[1:0]});
      rd(1'b1, DGF_CTRL_OFS, {31'h0000_0000, r[1]});
      rd(1'b0, DGF_STATUS_OFS, {30'h0000_0000, r[1:0]});
      pend <= 2'($urandom);
      @(negedge pclk);
      chk({30'h0000_0000, fval}, {30'h0000_0000, r[1:0] & pend});
      chk({30'h0000_0000, fen}, {30'h0000_0000, r[1:0]});
    end
    $display("secure test done");
    apb(1'b1, 1'b0, DGF_CTRL_OFS, 32'h0000_0000);
    apb(1'b1, 1'b1, DGF_CTRL_OFS, 32'hffff_ffff);
    rd(1'b1, DGF_CTRL_OFS, 32'h0000_0001);
    rd(1'b0, DGF_STATUS_OFS, 32'h0000_0002);
    apb(1'b1, 1'b1, DGF_CTRL_OFS, 32'h0000_0000);
    rd(1'b0, DGF_CTRL_OFS, 32'h0000_0000);
    $display("non-secure test done");
    apb(1'b1, 1'b0, DGF_CTRL_OFS, 32'h0000_0001);
    lock <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 1'b0, DGF_CTRL_OFS, 32'h0000_0000);
    rd(1'b0, DGF_STATUS_OFS, 32'h0000_0005);
    lock <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 1'b0, DGF_CTRL_OFS, 32'h0000_0002);
    rd(1'b0, DGF_CTRL_OFS, 32'h0000_0002);
    rd(1'b0, 12'h008, 32'h0000_0000);
    $display("lock test done");
    test_done;
  end
endmodule
